/* src/stdc_measure_config.sv */
// Configuration registers and measurement sequencer of a strain-gauge time-to-digital front end
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "stdc_consts.svh"

module stdc_measure_config (
    input  wire logic        clk,              // 40 MHz clock, also the fast clock
    input  wire logic        rst,              // Synchronous reset, active high
    input  wire logic        hsel,             // AHB slave select
    input  wire logic [31:0] haddr,            // AHB address
    input  wire logic [1:0]  htrans,           // AHB transfer type
    input  wire logic        hwrite,           // AHB write
    input  wire logic [2:0]  hsize,            // AHB size
    input  wire logic [31:0] hwdata,           // AHB write data
    input  wire logic        hready,           // AHB bus ready
    output logic             hreadyout,        // AHB slave ready
    output logic             hresp,            // AHB response, always OKAY
    output logic [31:0]      hrdata,           // AHB read data
    input  wire logic        slowClkPin,       // 32 kHz clock pin
    input  wire logic        resultValid,      // Half bridge results valid, pulse
    input  wire logic [23:0] halfResultA,      // First half bridge result
    input  wire logic [23:0] halfResultB,      // Second half bridge result
    input  wire logic [23:0] autoOffset,       // Computed auto offset
    input  wire logic        ronValid,         // On-resistance sample valid, pulse
    input  wire logic [23:0] ronSample,        // On-resistance compensation sample
    output logic [23:0]      bridgeResult,     // Combined and filtered result
    output logic             bridgeValid,      // Result strobe
    output logic [23:0]      ronFiltered,      // Filtered on-resistance value
    output logic             refTick,          // Reference clock tick
    output logic             cycleStrobe,      // End of a measurement cycle
    output logic             calibStrobe,      // Calibration measurement request
    output logic             gainStrobe,       // Gain compensation request
    output logic             blockDone,        // End of an averaging block
    output logic             dummyActive,      // Dummy or warm-up cycle running
    output logic             ringOscRun,       // Ring oscillator enable
    output logic [4:0]       calibDelay,       // Calibration point in fast periods
    output logic [6:0]       calAvgSamples,    // Calibration averaging count
    output logic [7:0]       offsetAvgSamples, // Auto offset averaging count
    output logic [14:0]      gainAvgSamples,   // Gain averaging count
    output logic [14:0]      ronAvgSamples,    // On-resistance averaging count
    output logic [23:0]      scaleFactor,      // Factor A, 8.16, output even when the second factor is selected
    output logic             scaleActive,      // Scaling enabled
    output logic             useSecondFactor,  // Second factor selected
    output logic             ronSimple         // Simplified on-resistance correction
);

    // Configuration words
    stdc_pkg::stdc_word_t regMain;
    stdc_pkg::stdc_word_t regAvgCyc;
    stdc_pkg::stdc_word_t regComp;
    stdc_pkg::stdc_word_t regMultA;
    stdc_pkg::stdc_word_t regRonA;
    stdc_pkg::stdc_word_t regRonB;
    stdc_pkg::stdc_word_t regDummy;
    stdc_pkg::stdc_word_t regOsc;
    stdc_pkg::stdc_word_t regBridge;
    logic                 runEn;
    logic                 initPulse;
    stdc_pkg::stdc_state_e state;

    // Bus pipeline
    logic        wrPend;
    logic [3:0]  wrIdx;
    logic        wrMapped;
    logic [3:0]  aIdx;
    logic        aMapped;
    logic        aValid;

    assign aIdx    = haddr[5:2];
    assign aMapped = (haddr[31:6] == 26'h0) && (aIdx <= `STDC_IDX_STATUS);
    assign aValid  = hsel && hready && htrans[1];

    // Zero wait state slave, every answer OKAY
    always_ff @(posedge clk) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Capture write address phase
    always_ff @(posedge clk) begin
        if (rst) begin
            wrPend   <= 1'b0;
            wrIdx    <= 4'h0;
            wrMapped <= 1'b0;
        end else begin
            wrPend   <= aValid && hwrite;
            wrIdx    <= aIdx;
            wrMapped <= aMapped;
        end
    end

    // Status word seen by software
    logic [31:0] statusWord;
    logic [11:0] avgCnt;
    assign statusWord = {16'h0, avgCnt, state};

    // Read data registered in the address phase
    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata <= 32'h0;
        end else if (aValid && !hwrite) begin
            hrdata <= 32'h0;
            if (aMapped) begin
                unique case (aIdx)
                    `STDC_IDX_MAIN:   hrdata <= {8'h0, regMain};
                    `STDC_IDX_AVGCYC: hrdata <= {8'h0, regAvgCyc};
                    `STDC_IDX_COMP:   hrdata <= {8'h0, regComp};
                    `STDC_IDX_MULT_A: hrdata <= {8'h0, regMultA};
                    `STDC_IDX_RON_A:  hrdata <= {8'h0, regRonA};
                    `STDC_IDX_RON_B:  hrdata <= {8'h0, regRonB};
                    `STDC_IDX_DUMMY:  hrdata <= {8'h0, regDummy};
                    `STDC_IDX_OSC:    hrdata <= {8'h0, regOsc};
                    `STDC_IDX_BRIDGE: hrdata <= {8'h0, regBridge};
                    `STDC_IDX_CTRL:   hrdata <= {31'h0, runEn};
                    default:          hrdata <= statusWord;
                endcase
            end
        end
    end

    logic wrHit;
    assign wrHit = wrPend && wrMapped;

    // Init pulse from software; restores defaults like a reset, except the factor word
    always_ff @(posedge clk) begin
        if (rst) begin
            initPulse <= 1'b0;
        end else begin
            initPulse <= wrHit && (wrIdx == `STDC_IDX_CTRL) && hwdata[`STDC_B_INIT];
        end
    end

    // Configuration words; the factor word survives init
    always_ff @(posedge clk) begin
        if (rst || initPulse) begin
            regMain   <= `STDC_RST_MAIN;
            regAvgCyc <= `STDC_RST_AVGCYC;
            regComp   <= `STDC_RST_COMP;
            regRonA   <= `STDC_RST_RON;
            regRonB   <= `STDC_RST_RON;
            regDummy  <= `STDC_RST_DUMMY;
            regOsc    <= `STDC_RST_ZERO;
            regBridge <= `STDC_RST_ZERO;
            runEn     <= 1'b0;
        end else if (wrHit) begin
            unique case (wrIdx)
                `STDC_IDX_MAIN:   regMain   <= hwdata[23:0];
                `STDC_IDX_AVGCYC: regAvgCyc <= hwdata[23:0];
                `STDC_IDX_COMP:   regComp   <= hwdata[23:0];
                `STDC_IDX_RON_A:  regRonA   <= hwdata[23:0];
                `STDC_IDX_RON_B:  regRonB   <= hwdata[23:0];
                `STDC_IDX_DUMMY:  regDummy  <= hwdata[23:0];
                `STDC_IDX_OSC:    regOsc    <= hwdata[23:0];
                `STDC_IDX_BRIDGE: regBridge <= hwdata[23:0];
                `STDC_IDX_CTRL:   runEn     <= hwdata[`STDC_B_RUN];
                default:          ;
            endcase
        end
    end

    // Factor is left alone by init, so software must load it first
    always_ff @(posedge clk) begin
        if (rst) begin
            regMultA <= `STDC_RST_ZERO;
        end else if (wrHit && wrIdx == `STDC_IDX_MULT_A) begin
            regMultA <= hwdata[23:0];
        end
    end

    // Slow clock pin synchroniser, three stages
    logic [2:0] slowSync;
    logic       slowLevel;
    always_ff @(posedge clk) begin
        if (rst) begin
            slowSync  <= 3'h0;
            slowLevel <= 1'b0;
        end else begin
            slowSync <= {slowSync[1:0], slowClkPin};
            if (slowSync[1] == slowSync[2]) begin
                slowLevel <= slowSync[2];
            end
        end
    end

    // Reference tick: slow clock edge when selected in range 1, else predivided fast clock
    logic [2:0] divCnt;
    logic [2:0] divMax;
    logic       slowMode;
    logic       slowEdge;
    assign slowMode = regMain[`STDC_B_SLOW_SEL] && !regMain[`STDC_B_RANGE2];
    assign divMax   = 3'((4'h1 << regMain[`STDC_F_PREDIV]) - 4'h1);
    assign slowEdge = (slowSync[1] == slowSync[2]) && slowSync[2] && !slowLevel;
    always_ff @(posedge clk) begin
        if (rst) begin
            divCnt  <= 3'h0;
            refTick <= 1'b0;
        end else begin
            divCnt  <= (divCnt >= divMax) ? 3'h0 : 3'(divCnt + 3'h1);
            refTick <= slowMode ? slowEdge : (divCnt >= divMax);
        end
    end

    // Cycle timer in reference periods; zero is treated as one
    logic [11:0] cycCnt;
    logic        cycEnd;
    logic        busy;
    assign busy   = (state != stdc_pkg::S_IDLE);
    assign cycEnd = refTick && busy && (cycCnt + 12'h1 >= regAvgCyc[`STDC_F_CYCLE]);
    always_ff @(posedge clk) begin
        if (rst || !busy) begin
            cycCnt <= 12'h0;
        end else if (refTick) begin
            cycCnt <= cycEnd ? 12'h0 : 12'(cycCnt + 12'h1);
        end
    end

    // Warm-up and dummy cycle counts
    logic [10:0] warmCycles;
    logic [2:0]  mfakeCycles;
    logic [10:0] leftCnt;
    assign warmCycles  = (regDummy[`STDC_F_WARM] == 3'h0) ? 11'h0 :
                         11'(11'h8 << regDummy[`STDC_F_WARM]);
    assign mfakeCycles = (regDummy[`STDC_F_MFAKE] == 2'h3) ? 3'h4 :
                         {1'b0, regDummy[`STDC_F_MFAKE]};

    // Sequencer
    logic blockEnd;
    assign blockEnd = cycEnd && (state == stdc_pkg::S_MEAS) &&
                      (avgCnt + 12'h1 >= regAvgCyc[`STDC_F_AVG]);
    always_ff @(posedge clk) begin
        if (rst || initPulse) begin
            state   <= stdc_pkg::S_IDLE;
            leftCnt <= 11'h0;
            avgCnt  <= 12'h0;
        end else begin
            unique case (state)
                stdc_pkg::S_IDLE: begin
                    if (runEn) begin
                        state   <= (warmCycles != 11'h0) ? stdc_pkg::S_WARM : stdc_pkg::S_DUMMY;
                        leftCnt <= (warmCycles != 11'h0) ? warmCycles : {8'h0, mfakeCycles};
                    end
                end
                stdc_pkg::S_WARM: begin
                    if (cycEnd) begin
                        leftCnt <= 11'(leftCnt - 11'h1);
                        if (leftCnt == 11'h1) begin
                            state   <= stdc_pkg::S_DUMMY;
                            leftCnt <= {8'h0, mfakeCycles};
                        end
                    end
                end
                stdc_pkg::S_DUMMY: begin
                    if (leftCnt == 11'h0) begin
                        state <= stdc_pkg::S_MEAS;
                    end else if (cycEnd) begin
                        leftCnt <= 11'(leftCnt - 11'h1);
                    end
                end
                stdc_pkg::S_MEAS: begin
                    if (blockEnd) begin
                        avgCnt  <= 12'h0;
                        leftCnt <= {8'h0, mfakeCycles};
                        state   <= runEn ? stdc_pkg::S_DUMMY : stdc_pkg::S_IDLE;
                    end else if (cycEnd) begin
                        avgCnt <= 12'(avgCnt + 12'h1);
                    end
                end
            endcase
        end
    end

    // Calibration every N cycles and gain compensation every N blocks
    logic [3:0] calCnt;
    logic [3:0] gainCnt;
    logic [3:0] gainInt;
    assign gainInt = regComp[`STDC_F_GAININT];
    always_ff @(posedge clk) begin
        if (rst || initPulse) begin
            calCnt      <= 4'h0;
            gainCnt     <= 4'h0;
            calibStrobe <= 1'b0;
            gainStrobe  <= 1'b0;
            cycleStrobe <= 1'b0;
            blockDone   <= 1'b0;
        end else begin
            cycleStrobe <= cycEnd;
            blockDone   <= blockEnd;
            calibStrobe <= 1'b0;
            gainStrobe  <= 1'b0;
            if (cycEnd) begin
                if (calCnt + 4'h1 >= regComp[`STDC_F_CALINT]) begin
                    calCnt      <= 4'h0;
                    calibStrobe <= 1'b1;
                end else begin
                    calCnt <= 4'(calCnt + 4'h1);
                end
            end
            // Code zero switches gain compensation off
            if (blockEnd && gainInt != 4'h0) begin
                if (gainCnt + 4'h1 >= gainInt) begin
                    gainCnt    <= 4'h0;
                    gainStrobe <= 1'b1;
                end else begin
                    gainCnt <= 4'(gainCnt + 4'h1);
                end
            end
        end
    end

    // Decoded counts and mode outputs, registered
    logic [3:0] gainCode;
    logic [3:0] ronCode;
    logic [2:0] offCode;
    assign gainCode = (regComp[`STDC_F_GAINAVG] == 4'h0) ? 4'h1 : regComp[`STDC_F_GAINAVG];
    assign ronCode  = (regComp[`STDC_F_RONAVG] == 4'h0) ? 4'h1 : regComp[`STDC_F_RONAVG];
    assign offCode  = (regComp[`STDC_F_OFFAVG] == 3'h0) ? 3'h1 : regComp[`STDC_F_OFFAVG];
    always_ff @(posedge clk) begin
        if (rst) begin
            calAvgSamples    <= 7'h01;
            offsetAvgSamples <= 8'h01;
            gainAvgSamples   <= 15'h0001;
            ronAvgSamples    <= 15'h0001;
            calibDelay       <= 5'h04;
            dummyActive      <= 1'b0;
            ringOscRun       <= 1'b0;
            scaleFactor      <= 24'h0;
            scaleActive      <= 1'b0;
            useSecondFactor  <= 1'b0;
            ronSimple        <= 1'b0;
        end else begin
            unique case (regMain[`STDC_F_CALAVG])
                2'h0: calAvgSamples <= 7'h01;
                2'h1: calAvgSamples <= 7'h08;
                2'h2: calAvgSamples <= 7'h20;
                2'h3: calAvgSamples <= 7'h40;
            endcase
            // Range 1 has no calibration averaging
            if (!regMain[`STDC_B_RANGE2]) begin
                calAvgSamples <= 7'h01;
            end
            offsetAvgSamples <= 8'(8'h1 << (offCode - 3'h1));
            gainAvgSamples   <= 15'(15'h1 << (gainCode - 4'h1));
            ronAvgSamples    <= 15'(15'h1 << (ronCode - 4'h1));
            calibDelay       <= 5'({1'b0, regDummy[`STDC_F_CALIB_DELAY]} + `STDC_CALIB_DELAY_ADD);
            dummyActive      <= (state == stdc_pkg::S_WARM) || (state == stdc_pkg::S_DUMMY);
            ringOscRun       <= regOsc[`STDC_B_RUNTIME] || busy;
            scaleFactor      <= regMultA;
            scaleActive      <= regMain[`STDC_B_SCALE_EN];
            useSecondFactor  <= regBridge[`STDC_B_SECOND_EN];
            ronSimple        <= regMain[`STDC_B_RON_SIMPLE];
        end
    end

    // Bridge combination, auto offset, then optional two-point smoothing
    logic [23:0] combined;
    logic [23:0] offsetted;
    always_comb begin
        if (regMain[`STDC_B_ADD]) begin
            combined = 24'(halfResultA + halfResultB);
        end else if (regMain[`STDC_B_DIFF]) begin
            combined = 24'(halfResultB - halfResultA);
        end else begin
            combined = halfResultA;
        end
        offsetted = regMain[`STDC_B_OFFSET_SEL] ? 24'(combined - autoOffset) : combined;
    end

    // Extra filter averages with the previous result; costs half a step of lag
    always_ff @(posedge clk) begin
        if (rst || initPulse) begin
            bridgeResult <= 24'h0;
            bridgeValid  <= 1'b0;
        end else begin
            bridgeValid <= resultValid;
            if (resultValid) begin
                bridgeResult <= regComp[`STDC_B_EXTRA_FILT] ?
                                24'(({1'b0, bridgeResult} + {1'b0, offsetted}) >> 1) : offsetted;
            end
        end
    end

    // Spike filter limits each step of the on-resistance value
    logic [23:0] ronDelta;
    assign ronDelta = (ronSample > ronFiltered) ? 24'(ronSample - ronFiltered) : 24'(ronFiltered - ronSample);
    always_ff @(posedge clk) begin
        if (rst || initPulse) begin
            ronFiltered <= `STDC_RST_RON;
        end else if (ronValid) begin
            if (!regOsc[`STDC_B_SPIKE] || ronDelta <= `STDC_SPIKE_LIMIT) begin
                ronFiltered <= ronSample;
            end else if (ronSample > ronFiltered) begin
                ronFiltered <= 24'(ronFiltered + `STDC_SPIKE_LIMIT);
            end else begin
                ronFiltered <= 24'(ronFiltered - `STDC_SPIKE_LIMIT);
            end
        end
    end

endmodule // stdc_measure_config

`default_nettype wire

/* src/stdc_consts.svh */
// Offsets, field positions, reset values and timing figures of the measurement configuration block
`ifndef STDC_CONSTS_SVH
`define STDC_CONSTS_SVH
// Register indices; byte address is four times the index
`define STDC_IDX_MAIN      4'h0
`define STDC_IDX_AVGCYC    4'h1
`define STDC_IDX_COMP      4'h2
`define STDC_IDX_MULT_A    4'h3
`define STDC_IDX_RON_A     4'h4
`define STDC_IDX_RON_B     4'h5
`define STDC_IDX_DUMMY     4'h6
`define STDC_IDX_OSC       4'h7
`define STDC_IDX_BRIDGE    4'h8
`define STDC_IDX_CTRL      4'h9
`define STDC_IDX_STATUS    4'hA
// Main configuration fields
`define STDC_B_RANGE2      3
`define STDC_B_OFFSET_SEL  7
`define STDC_B_ADD         14
`define STDC_B_DIFF        15
`define STDC_B_SLOW_SEL    16
`define STDC_F_CALAVG      19:18
`define STDC_F_PREDIV      21:20
`define STDC_B_RON_SIMPLE  22
`define STDC_B_SCALE_EN    23
// Averaging and cycle time
`define STDC_F_AVG         11:0
`define STDC_F_CYCLE       23:12
// Compensation rates
`define STDC_F_CALINT      3:0
`define STDC_F_OFFAVG      6:4
`define STDC_B_EXTRA_FILT  7
`define STDC_F_GAININT     11:8
`define STDC_F_GAINAVG     15:12
`define STDC_F_RONAVG      19:16
// Dummy cycles and calibration delay
`define STDC_F_MFAKE       1:0
`define STDC_F_WARM        4:2
`define STDC_F_CALIB_DELAY      16:13
// Oscillator and bridge control
`define STDC_B_RUNTIME     0
`define STDC_B_SPIKE       1
`define STDC_B_SECOND_EN   0
// Control register bits
`define STDC_B_RUN         0
`define STDC_B_INIT        1
// Reset values
`define STDC_RST_MAIN      24'h000000
`define STDC_RST_AVGCYC    24'h001001
`define STDC_RST_COMP      24'h001111
`define STDC_RST_RON       24'h800000
`define STDC_RST_DUMMY     24'h002000
`define STDC_RST_ZERO      24'h000000
// Extra delay of the calibration point in fast clock periods
`define STDC_CALIB_DELAY_ADD    5'h03
// Largest jump a new on-resistance value may make while spike filtered
`define STDC_SPIKE_LIMIT   24'h001000
`endif

/* src/stdc_pkg.sv */
// Types shared by the measurement configuration block
`default_nettype none
package stdc_pkg;
    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        S_IDLE  = 4'b0001,
        S_WARM  = 4'b0010,
        S_DUMMY = 4'b0100,
        S_MEAS  = 4'b1000
    } stdc_state_e;
    typedef logic [23:0] stdc_word_t;
endpackage
`default_nettype wire

/* test/stdc_measure_config_asserts.sv */
// Port checker for the measurement configuration block
`timescale 1ns/10ps
`default_nettype none
module stdc_measure_config_asserts (
    input wire logic        clk,              // Clock
    input wire logic        rst,              // Reset
    input wire logic        hsel,             // Select
    input wire logic [1:0]  htrans,           // Transfer
    input wire logic        hwrite,           // Write
    input wire logic        resultValid,      // Results in
    input wire logic        bridgeValid,      // Result out
    input wire logic [4:0]  calibDelay,       // Cal point
    input wire logic [6:0]  calAvgSamples,    // Cal count
    input wire logic [7:0]  offsetAvgSamples, // Offset count
    input wire logic [14:0] gainAvgSamples,   // Gain count
    input wire logic [14:0] ronAvgSamples,    // Ron count
    input wire logic [23:0] scaleFactor       // Factor A
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Result strobe follows its inputs by exactly one cycle
    sequence res_in; resultValid; endsequence
    sequence res_out; ##1 bridgeValid; endsequence
    // Factor only moves after a write has had time to land
    sequence no_wr; !(hsel && htrans[1] && hwrite) [*3]; endsequence
    result_latency_a: assert property (res_in |-> res_out) else $error("result late");
    result_quiet_a: assert property (!resultValid |=> !bridgeValid) else $error("stray result");
    calib_point_a: assert property (calibDelay inside {[4:18]}) else $error("cal point");
    cal_avg_a: assert property (calAvgSamples inside {1, 8, 32, 64}) else $error("cal avg");
    offset_avg_a: assert property ($onehot(offsetAvgSamples)) else $error("offset avg");
    gain_avg_a: assert property ($onehot(gainAvgSamples)) else $error("gain avg");
    ron_avg_a: assert property ($onehot(ronAvgSamples)) else $error("ron avg");
    scale_hold_a: assert property (no_wr |=> $stable(scaleFactor)) else $error("factor moved");
endmodule // stdc_measure_config_asserts
bind stdc_measure_config stdc_measure_config_asserts u_chk (.clk, .rst, .hsel, .htrans, .hwrite,
    .resultValid, .bridgeValid, .calibDelay, .calAvgSamples, .offsetAvgSamples, .gainAvgSamples,
    .ronAvgSamples, .scaleFactor);
`default_nettype wire

/* test/stdc_front_model.sv */
// Front-end model handing half bridge results and on-resistance samples
`timescale 1ns/10ps
`default_nettype none
module stdc_front_model (
    input  wire logic   clk,         // Clock
    output logic        resultValid, // Result strobe
    output logic [23:0] halfResultA, // First half
    output logic [23:0] halfResultB, // Second half
    output logic [23:0] autoOffset,  // Offset
    output logic        ronValid,    // Sample strobe
    output logic [23:0] ronSample    // Sample
);
    // Idle values are junk on purpose
    initial begin
        {resultValid, ronValid} = 2'b00;
        {halfResultA, halfResultB, autoOffset, ronSample} = {4{24'hA5A5A5}};
    end
    // One-cycle pulse; data inverted afterwards so a stale value never matches
    task send(input logic [23:0] a, input logic [23:0] b, input logic [23:0] o);
        @(posedge clk);
        {resultValid, halfResultA, halfResultB, autoOffset} <= {1'b1, a, b, o};
        @(posedge clk);
        {resultValid, halfResultA, halfResultB, autoOffset} <= {1'b0, ~a, ~b, ~o};
    endtask
    task ron(input logic [23:0] s);
        @(posedge clk);
        {ronValid, ronSample} <= {1'b1, s};
        @(posedge clk);
        {ronValid, ronSample} <= {1'b0, ~s};
    endtask
endmodule // stdc_front_model
`default_nettype wire

/* test/stdc_measure_config_bench.sv */
// Self-checking bench of the measurement configuration block
`timescale 1ns/10ps
`default_nettype none
module stdc_measure_config_bench;
    logic clk = 0, rst = 1, hsel = 0, hwrite = 0;
    logic [1:0] htrans = 0;
    logic [3:0] slowCnt = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic hreadyout, resultValid, ronValid, bridgeValid, cycleStrobe, calibStrobe, blockDone;
    logic ringOscRun, scaleActive, useSecondFactor, ronSimple, gainStrobe, dummyActive;
    logic [23:0] halfResultA, halfResultB, autoOffset, ronSample, bridgeResult, ronFiltered, scaleFactor;
    logic [4:0] calibDelay;
    logic [6:0] calAvgSamples;
    logic [7:0] offsetAvgSamples;
    logic [14:0] gainAvgSamples, ronAvgSamples;
    int n_errors = 0, compares = 0;
    stdc_measure_config DUT (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .slowClkPin(slowCnt[3]), .resultValid, .halfResultA,
        .halfResultB, .autoOffset, .ronValid, .ronSample, .bridgeResult, .bridgeValid, .ronFiltered,
        .refTick(), .cycleStrobe, .calibStrobe, .gainStrobe, .blockDone, .dummyActive, .ringOscRun,
        .calibDelay, .calAvgSamples, .offsetAvgSamples, .gainAvgSamples, .ronAvgSamples, .scaleFactor,
        .scaleActive, .useSecondFactor, .ronSimple);
    stdc_front_model FE (.clk, .resultValid, .halfResultA, .halfResultB, .autoOffset, .ronValid, .ronSample);
    always #12.5 clk = ~clk;
    // Slow clock pin, one rising edge every 16 clocks
    always @(posedge clk) slowCnt <= 4'(slowCnt + 4'h1);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Single AHB transfer; address phase held until ready, then data phase
    task xfer(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 26'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task t_regs;
        logic [5:0] a[6];
        logic [23:0] v[6];
        logic [31:0] q;
        a = '{6'h04, 6'h08, 6'h10, 6'h14, 6'h18, 6'h2C};
        v = '{24'h001001, 24'h001111, 24'h800000, 24'h800000, 24'h002000, 24'h0};
        wr(6'h10, 32'h800000);
        for (int i = 0; i < 6; i++) begin
            xfer(1'b0, a[i], 32'h0, q);
            chk(q, {8'h00, v[i]});
        end
    endtask
    task automatic t_decode;
        int ca[4] = '{1, 8, 32, 64};
        for (int c = 1; c < 8; c++) begin
            wr(6'h08, (c << 16) | (c << 12) | (c << 4) | 1);
            settle;
            chk(offsetAvgSamples, 1 << (c - 1));
            chk(gainAvgSamples, 1 << (c - 1));
            chk(ronAvgSamples, 1 << (c - 1));
        end
        for (int c = 1; c < 16; c++) begin
            wr(6'h18, c << 13);
            settle;
            chk(calibDelay, c + 3);
        end
        for (int k = 0; k < 4; k++) begin
            wr(6'h00, 32'h8 | (k << 18));
            settle;
            chk(calAvgSamples, ca[k]);
        end
    endtask
    // Sum, difference, sum winning over difference, sum less auto offset
    task automatic t_result;
        logic [31:0] m[4] = '{32'h4000, 32'h8000, 32'hC000, 32'h4080};
        logic [23:0] e[4] = '{24'h15, 24'h0B, 24'h15, 24'h14};
        for (int i = 0; i < 4; i++) begin
            wr(6'h00, m[i]);
            FE.send(24'h5, 24'h10, 24'h1);
            #1;
            chk(bridgeValid, 1'b1);
            chk(bridgeResult, e[i]);
        end
        wr(6'h08, 32'h80);
        FE.send(24'h0, 24'h1A, 24'h0);
        #1;
        chk(bridgeResult, 24'h17);
    endtask
    task t_misc;
        wr(6'h1C, 32'h2);
        settle;
        chk(ringOscRun, 1'b0);
        wr(6'h0C, 32'h018000); // Factor before scaling on
        wr(6'h00, 32'hC00000);
        wr(6'h20, 32'h1);
        wr(6'h1C, 32'h3);
        settle;
        chk(scaleFactor, 24'h018000);
        chk(scaleActive, 1'b1);
        chk(ronSimple, 1'b1);
        chk(useSecondFactor, 1'b1);
        chk(ringOscRun, 1'b1);
        FE.ron(24'h900000);
        #1;
        chk(ronFiltered, 24'h801000);
    endtask
    // Counts cycles, calibrations and clocks up to the next block end
    task blk(output int nc, output int nk, output int nt);
        {nc, nk, nt} = 0;
        for (int i = 0; i < 500 && blockDone !== 1'b1 || i == 0; i++) begin
            @(posedge clk);
            #1;
            nt++;
            nc += (cycleStrobe === 1'b1);
            nk += (calibStrobe === 1'b1);
        end
    endtask
    task t_seq;
        int nc, nk, nt;
        wr(6'h18, 32'h2001);
        wr(6'h08, 32'h1111);
        wr(6'h04, 32'h002003);
        wr(6'h24, 32'h1);
        for (int p = 0; p < 3; p++) begin
            wr(6'h00, p[1] ? 32'h10000 : p << 20);
            repeat (2) blk(nc, nk, nt);
            blk(nc, nk, nt);
            chk(gainStrobe, 1'b1);
            chk(nc, 4);
            chk(nk, 4);
            chk(nt, p[1] ? 128 : 8 << p);
            settle;
            chk(dummyActive, 1'b1);
        end
    endtask
    task report_and_stop;
        $display("Comparisons %0d, errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        t_regs;
        t_decode;
        t_result;
        t_misc;
        t_seq;
        report_and_stop;
    end
    // Whole run needs under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        report_and_stop;
    end
endmodule // stdc_measure_config_bench
`default_nettype wire
